// *** sdram_cmd_pkg.sv ***
// Summary of operation
// - All inputs except the asynchronous reset sampled on rising clock; clock advances burst counter and output registers.
// - Four independent banks, each 4096 rows by 256 columns of 16-bit words.
// - Activate latches bank from bank select and row from twelve address bits.
// - Read or write address gives start column; device generates following columns.
// - Burst lengths 1, 2, 4 or 8 programmable; burst terminate ends early.
// - Auto precharge closes the row by itself at the end of the burst.
// - A new column address is accepted every cycle, even mid-burst.
// - One bank may precharge while another bank is accessed.
// - Clock enable high runs internal clocking; low freezes it.
// - Clock enable drop picks power-down, self refresh, deepest sleep or suspend by bank state.
// - Commands decoded only when chip select registered low; ignored when high.
// - Command encoded by chip select, row, column and write strobes on one edge.
// - Temperature sensor enabled after reset; partial array refresh set via extended mode.
// - Byte mask high masks write data; on reads tristates its lane two clocks later.
// - Read or write column uses eight low address bits; bit ten asks auto precharge.
// - Precharge with bit ten high closes all banks, else only the selected bank.
// - Mode load: bank select chooses mode or extended mode; address holds op-code.
package sdram_cmd_pkg;
  localparam int NUM_BANKS = 4;
  localparam int ROW_BITS  = 12;
  localparam int COL_BITS  = 8;
  localparam int BANK_BITS = 2;
  localparam int DATA_BITS = 16;
  localparam int PRE_BIT   = 10;
  localparam int MASK_LAT  = 2;
  localparam int BL_FIELD_LSB = 0;
  localparam int BL_FIELD_W   = 3;
  localparam int PARTIAL_ARRAY_REFRESH_LSB     = 0;
  localparam int PARTIAL_ARRAY_REFRESH_W       = 3;
  localparam int TEMP_COMPENSATED_REFRESH_LSB     = 3;
  localparam int TEMP_COMPENSATED_REFRESH_W       = 2;
  localparam logic [11:0] MODE_RESET = 12'h000;
  localparam logic [11:0] EXT_RESET  = 12'h000;
  localparam logic [1:0]  TEMP_COMPENSATED_REFRESH_RESET = 2'h0;
  localparam logic [1:0]  SEL_MODE   = 2'h0;
  localparam logic [1:0]  SEL_EXT    = 2'h2;
  localparam int AP_CYCLES = 2;
  // Strobe codes {row, column, write}, active low.
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [2:0] {
    PWR_RUN, PWR_PRE_DOWN, PWR_ACT_DOWN, PWR_SELF_REF, PWR_DEEPEST, PWR_SUSPEND
  } pwr_state_e;
endpackage

// *** sdram_bank.sv ***
`timescale 1ns/1ps
module sdram_bank #(
  parameter int ROW_W = 12,
  parameter int AP_W  = 2
) (
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             run_in,
  input  wire logic             act_in,
  input  wire logic             pre_in,
  input  wire logic             ap_start_in,
  input  wire logic [ROW_W-1:0] row_in,
  output logic                  open_out,
  output logic [ROW_W-1:0]      row_out
);
  logic [AP_W-1:0] ap_cnt_reg;
  logic [AP_W-1:0] ap_cnt_next;
  logic            open_next;
  assign ap_cnt_next = ap_start_in ? AP_W'(sdram_cmd_pkg::AP_CYCLES)
                     : (ap_cnt_reg != '0 ? ap_cnt_reg - 1'b1 : ap_cnt_reg);
  assign open_next = act_in ? 1'b1
                   : (pre_in || ap_cnt_reg == AP_W'(1)) ? 1'b0 : open_out;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_out   <= 1'b0;
      row_out    <= '0;
      ap_cnt_reg <= '0;
    end else if (run_in) begin
      open_out   <= open_next;
      ap_cnt_reg <= ap_cnt_next;
      if (act_in) begin
        row_out <= row_in;
      end
    end
  end
endmodule

// *** sdram_command_interface.sv ***
`timescale 1ns/1ps
module sdram_command_interface (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        row_strobe_n_in,
  input  wire logic        col_strobe_n_in,
  input  wire logic        write_en_n_in,
  input  wire logic [1:0]  bank_select_in,
  input  wire logic [11:0] address_bus_in,
  input  wire logic        low_byte_mask_in,
  input  wire logic        high_byte_mask_in,
  input  wire logic        deepest_sleep_in,
  output logic [3:0]       bank_open_out,
  output logic [1:0]       access_bank_out,
  output logic [11:0]      access_row_out,
  output logic [7:0]       access_col_out,
  output logic             access_valid_out,
  output logic             access_write_out,
  output logic [1:0]       write_lane_en_out,
  output logic [1:0]       read_lane_oe_out,
  output logic [2:0]       pwr_state_out,
  output logic             input_buf_en_out,
  output logic [2:0]       partial_array_refresh_out,
  output logic [1:0]       temp_compensated_refresh_out,
  output logic [11:0]      mode_reg_out
);
  logic        cke_s1_reg;
  logic        cke_s2_reg;
  logic        run;
  logic        cmd_en;
  logic [2:0]  cmd;
  logic        is_act;
  logic        is_rd;
  logic        is_wr;
  logic        is_pre;
  logic        is_bst;
  logic        is_mrs;
  logic        is_col;
  logic [3:0]  act_hit;
  logic [3:0]  pre_hit;
  logic [3:0]  ap_hit;
  logic [3:0]  open_w;
  logic [11:0] row_w [4];
  logic [11:0] ext_reg;
  logic [3:0]  burst_len;
  logic [3:0]  burst_cnt_reg;
  logic [3:0]  burst_cnt_next;
  logic [7:0]  col_reg;
  logic [7:0]  col_next;
  logic [1:0]  bank_reg;
  logic        wr_reg;
  logic        ap_reg;
  logic        burst_last;
  logic [1:0]  mask_pipe_reg [2];
  sdram_cmd_pkg::pwr_state_e pwr_reg;
  sdram_cmd_pkg::pwr_state_e pwr_next;
  logic        asleep;

  // Clock enable is a pin; synchronised before use.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cke_s1_reg <= 1'b1;
      cke_s2_reg <= 1'b1;
    end else begin
      cke_s1_reg <= clk_en_in;
      cke_s2_reg <= cke_s1_reg;
    end
  end

  assign asleep = (pwr_reg == sdram_cmd_pkg::PWR_PRE_DOWN) ||
                  (pwr_reg == sdram_cmd_pkg::PWR_ACT_DOWN) ||
                  (pwr_reg == sdram_cmd_pkg::PWR_SELF_REF);
  assign run = cke_s2_reg && (pwr_reg == sdram_cmd_pkg::PWR_RUN);
  assign input_buf_en_out = !asleep && (pwr_reg != sdram_cmd_pkg::PWR_DEEPEST);

  // Command decode.
  assign cmd_en = run && !chip_sel_n_in;
  assign cmd    = {row_strobe_n_in, col_strobe_n_in, write_en_n_in};
  assign is_act = cmd_en && cmd == sdram_cmd_pkg::CMD_ACT;
  assign is_rd  = cmd_en && cmd == sdram_cmd_pkg::CMD_RD;
  assign is_wr  = cmd_en && cmd == sdram_cmd_pkg::CMD_WR;
  assign is_pre = cmd_en && cmd == sdram_cmd_pkg::CMD_PRE;
  assign is_bst = cmd_en && cmd == sdram_cmd_pkg::CMD_BST;
  assign is_mrs = cmd_en && cmd == sdram_cmd_pkg::CMD_MRS;
  assign is_col = (is_rd || is_wr) && open_w[bank_select_in];

  assign burst_len = 4'h1 << mode_reg_out[sdram_cmd_pkg::BL_FIELD_LSB +: 2];
  assign burst_last = burst_cnt_reg == 4'h1;

  genvar g;
  generate
    for (g = 0; g < sdram_cmd_pkg::NUM_BANKS; g++) begin : g_bank
      assign act_hit[g] = is_act && bank_select_in == 2'(g);
      assign pre_hit[g] = is_pre && (address_bus_in[sdram_cmd_pkg::PRE_BIT] ||
                                     bank_select_in == 2'(g));
      assign ap_hit[g]  = ap_reg && burst_last && bank_reg == 2'(g) && run &&
                          !(is_col && bank_select_in == 2'(g));
      sdram_bank #(
        .ROW_W (sdram_cmd_pkg::ROW_BITS),
        .AP_W  (2)
      ) u_bank (
        .ref_clk_in  (ref_clk_in),
        .nrst_in     (nrst_in),
        .run_in      (run),
        .act_in      (act_hit[g]),
        .pre_in      (pre_hit[g]),
        .ap_start_in (ap_hit[g]),
        .row_in      (address_bus_in),
        .open_out    (open_w[g]),
        .row_out     (row_w[g])
      );
    end
  endgenerate
  assign bank_open_out = open_w;

  // Burst engine: a new column restarts the burst at once.
  assign burst_cnt_next = is_col ? burst_len
                        : is_bst ? 4'h0
                        : (burst_cnt_reg != 4'h0) ? burst_cnt_reg - 4'h1 : 4'h0;
  assign col_next = is_col ? address_bus_in[sdram_cmd_pkg::COL_BITS-1:0]
                  : col_reg + 8'h01;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      burst_cnt_reg <= 4'h0;
      col_reg       <= 8'h00;
      bank_reg      <= 2'h0;
      wr_reg        <= 1'b0;
      ap_reg        <= 1'b0;
    end else if (run) begin
      burst_cnt_reg <= burst_cnt_next;
      col_reg       <= col_next;
      if (is_col) begin
        bank_reg <= bank_select_in;
        wr_reg   <= is_wr;
        ap_reg   <= address_bus_in[sdram_cmd_pkg::PRE_BIT];
      end else if (is_bst) begin
        ap_reg <= 1'b0;
      end
    end
  end

  // Access outputs registered each clock while running.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      access_valid_out  <= 1'b0;
      access_write_out  <= 1'b0;
      access_bank_out   <= 2'h0;
      access_row_out    <= 12'h000;
      access_col_out    <= 8'h00;
      write_lane_en_out <= 2'h0;
    end else if (run) begin
      access_valid_out  <= is_col || (burst_cnt_reg > 4'h1 && !is_bst);
      access_write_out  <= is_col ? is_wr : wr_reg;
      access_bank_out   <= is_col ? bank_select_in : bank_reg;
      access_row_out    <= row_w[is_col ? bank_select_in : bank_reg];
      access_col_out    <= col_next;
      write_lane_en_out <= {!high_byte_mask_in, !low_byte_mask_in};
    end
  end

  // Read mask latency pipe.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_pipe_reg[0] <= 2'h0;
      mask_pipe_reg[1] <= 2'h0;
    end else if (run) begin
      mask_pipe_reg[0] <= {high_byte_mask_in, low_byte_mask_in};
      mask_pipe_reg[1] <= mask_pipe_reg[0];
    end
  end
  assign read_lane_oe_out = ~mask_pipe_reg[1] & {2{!wr_reg && burst_cnt_reg != 4'h0}};

  // Mode and extended mode registers.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg_out <= sdram_cmd_pkg::MODE_RESET;
      ext_reg      <= sdram_cmd_pkg::EXT_RESET;
    end else if (is_mrs && burst_cnt_reg == 4'h0) begin
      if (bank_select_in == sdram_cmd_pkg::SEL_EXT) begin
        ext_reg <= address_bus_in;
      end else if (bank_select_in == sdram_cmd_pkg::SEL_MODE) begin
        mode_reg_out <= address_bus_in;
      end
    end
  end
  assign partial_array_refresh_out =
    ext_reg[sdram_cmd_pkg::PARTIAL_ARRAY_REFRESH_LSB +: sdram_cmd_pkg::PARTIAL_ARRAY_REFRESH_W];
  assign temp_compensated_refresh_out =
    ext_reg[sdram_cmd_pkg::TEMP_COMPENSATED_REFRESH_LSB +: sdram_cmd_pkg::TEMP_COMPENSATED_REFRESH_W];

  // Low-power selection.
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      sdram_cmd_pkg::PWR_RUN: begin
        if (!cke_s2_reg) begin
          if (burst_cnt_reg != 4'h0) begin
            pwr_next = sdram_cmd_pkg::PWR_SUSPEND;
          end else if (open_w != 4'h0) begin
            pwr_next = sdram_cmd_pkg::PWR_ACT_DOWN;
          end else if (deepest_sleep_in) begin
            pwr_next = sdram_cmd_pkg::PWR_DEEPEST;
          end else if (!chip_sel_n_in && {row_strobe_n_in, col_strobe_n_in} == 2'h0) begin
            pwr_next = sdram_cmd_pkg::PWR_SELF_REF;
          end else begin
            pwr_next = sdram_cmd_pkg::PWR_PRE_DOWN;
          end
        end
      end
      sdram_cmd_pkg::PWR_PRE_DOWN, sdram_cmd_pkg::PWR_ACT_DOWN,
      sdram_cmd_pkg::PWR_SELF_REF, sdram_cmd_pkg::PWR_DEEPEST,
      sdram_cmd_pkg::PWR_SUSPEND: begin
        if (cke_s2_reg) begin
          pwr_next = sdram_cmd_pkg::PWR_RUN;
        end
      end
      default: pwr_next = sdram_cmd_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_reg <= sdram_cmd_pkg::PWR_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end
  assign pwr_state_out = pwr_reg;

  // Checks.
  a_cs_masks_cmd: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    chip_sel_n_in |=> (bank_open_out & ~$past(bank_open_out)) == 4'h0 &&
    $stable(mode_reg_out)) else $error("command taken with chip select high");
  a_act_opens_bank: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    act_hit[0] |=> bank_open_out[0]) else $error("activate did not open bank");
  a_act_row: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    act_hit[2] |=> row_w[2] == $past(address_bus_in))
    else $error("activate row not latched");
  a_access_row: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_col |=> access_row_out == row_w[$past(bank_select_in)])
    else $error("access row not from the selected bank");
  a_pre_all: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_pre && address_bus_in[10] && !is_act |=> bank_open_out == 4'h0)
    else $error("precharge all left a bank open");
  a_pre_one_bank: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_pre && !address_bus_in[10] && bank_select_in == 2'h3 |=> !bank_open_out[3])
    else $error("precharge left the bank open");
  a_burst_len: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_col |=> burst_cnt_reg == burst_len) else $error("burst length wrong");
  a_bst_stops: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_bst && !is_col |=> burst_cnt_reg == 4'h0) else $error("terminate ignored");
  a_mode_in_burst: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_mrs && burst_cnt_reg != 4'h0 |=> $stable(mode_reg_out))
    else $error("mode changed during a burst");
  a_closed_bank: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (is_rd || is_wr) && !open_w[bank_select_in] && burst_cnt_reg == 4'h0 |=>
    !access_valid_out) else $error("access to a closed bank");
  a_col_start: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_col |=> access_valid_out && access_col_out == $past(address_bus_in[7:0]))
    else $error("start column wrong");
  a_col_incr: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    run && !is_col ##1 run |-> col_reg == $past(col_reg) + 8'h01)
    else $error("column did not advance");
  a_ap_closes: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ap_hit[1] ##1 run ##1 run && !act_hit[1] |=> !bank_open_out[1])
    else $error("auto precharge left the row open");
  a_wr_lanes: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    run |=> write_lane_en_out == ~$past({high_byte_mask_in, low_byte_mask_in}))
    else $error("write lane enables wrong");
  a_mask_lat: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    run ##1 run ##1 run |-> mask_pipe_reg[1] == $past({high_byte_mask_in, low_byte_mask_in}, 2))
    else $error("mask latency wrong");

  // Power-state checks.
  a_freeze_cke: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !run |=> $stable(burst_cnt_reg)) else $error("state moved while frozen");
  a_buf_off: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_SELF_REF |-> !input_buf_en_out)
    else $error("buffers on in self refresh");
  a_suspend_entry: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_RUN && !cke_s2_reg && burst_cnt_reg != 4'h0 |=>
    pwr_reg == sdram_cmd_pkg::PWR_SUSPEND) else $error("no clock suspend in a burst");
  a_deepest_entry: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_RUN && !cke_s2_reg && burst_cnt_reg == 4'h0 &&
    open_w == 4'h0 && deepest_sleep_in |=> pwr_reg == sdram_cmd_pkg::PWR_DEEPEST)
    else $error("deepest sleep not entered");
  a_wake_exit: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg != sdram_cmd_pkg::PWR_RUN && cke_s2_reg |=> pwr_reg == sdram_cmd_pkg::PWR_RUN)
    else $error("low-power state not left");

  // Scenario covers.
  c_read_burst: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    is_act ##[1:4] is_rd);
  c_auto_pre: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) |ap_hit);
  c_suspend: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_SUSPEND);
  c_self_ref: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_SELF_REF);
  c_deepest: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pwr_reg == sdram_cmd_pkg::PWR_DEEPEST);
endmodule

// *** sdram_ctrl_model.sv ***
`timescale 1ns/1ps
module sdram_ctrl_model (
  input  wire logic        ref_clk_in,
  output logic             clk_en_out,
  output logic             chip_sel_n_out,
  output logic [2:0]       strobe_n_out,
  output logic [1:0]       bank_select_out,
  output logic [11:0]      address_bus_out,
  output logic [1:0]       byte_mask_out,
  output logic             deepest_sleep_out
);
  // Chip select stays high until the first command is sent.
  initial begin
    clk_en_out        = 1'b1;
    chip_sel_n_out    = 1'b1;
    strobe_n_out      = sdram_cmd_pkg::CMD_NOP;
    bank_select_out   = 2'h0;
    address_bus_out   = 12'h000;
    byte_mask_out     = 2'h0;
    deepest_sleep_out = 1'b0;
  end
  // Drives one command just after a rising edge; it stands until the next call.
  task automatic issue(input logic cs_n, input logic [2:0] code, input logic [1:0] bank,
                       input logic [11:0] addr);
    @(posedge ref_clk_in);
    #1;
    chip_sel_n_out  = cs_n;
    strobe_n_out    = code;
    bank_select_out = bank;
    address_bus_out = addr;
  endtask
  // Deselects the device; the address lines no longer hold the last value.
  task automatic idle();
    issue(1'b1, sdram_cmd_pkg::CMD_NOP, ~bank_select_out, ~address_bus_out);
  endtask
  // Sets clock enable, byte masks and the deepest sleep request without waiting.
  task automatic set_side(input logic ce, input logic [1:0] mask, input logic ds);
    clk_en_out        = ce;
    byte_mask_out     = mask;
    deepest_sleep_out = ds;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] MRS = sdram_cmd_pkg::CMD_MRS;
  localparam logic [2:0] ACT = sdram_cmd_pkg::CMD_ACT;
  localparam logic [2:0] RD  = sdram_cmd_pkg::CMD_RD;
  localparam logic [2:0] WR  = sdram_cmd_pkg::CMD_WR;
  localparam logic [2:0] PRE = sdram_cmd_pkg::CMD_PRE;
  localparam logic [2:0] BST = sdram_cmd_pkg::CMD_BST;
  localparam logic [2:0] REF = sdram_cmd_pkg::CMD_REF;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        ce, cs_n, ds, acc_valid, acc_write, buf_en;
  logic [1:0]  bsel, mask, acc_bank, wr_lane, rd_oe, tcr;
  logic [2:0]  strb, pwr, par;
  logic [3:0]  bank_open;
  logic [7:0]  acc_col, last_col, held_col;
  logic [11:0] addr, acc_row, mode_reg;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  int          beats;
  int          i;
  always #10 ref_clk_in = ~ref_clk_in;
  sdram_ctrl_model u_ctrl (.ref_clk_in(ref_clk_in), .clk_en_out(ce), .chip_sel_n_out(cs_n),
    .strobe_n_out(strb), .bank_select_out(bsel), .address_bus_out(addr),
    .byte_mask_out(mask), .deepest_sleep_out(ds));
  sdram_command_interface u_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(ce),
    .chip_sel_n_in(cs_n), .row_strobe_n_in(strb[2]), .col_strobe_n_in(strb[1]),
    .write_en_n_in(strb[0]), .bank_select_in(bsel), .address_bus_in(addr),
    .low_byte_mask_in(mask[0]), .high_byte_mask_in(mask[1]), .deepest_sleep_in(ds),
    .bank_open_out(bank_open), .access_bank_out(acc_bank), .access_row_out(acc_row),
    .access_col_out(acc_col), .access_valid_out(acc_valid), .access_write_out(acc_write),
    .write_lane_en_out(wr_lane), .read_lane_oe_out(rd_oe), .pwr_state_out(pwr),
    .input_buf_en_out(buf_en), .partial_array_refresh_out(par),
    .temp_compensated_refresh_out(tcr), .mode_reg_out(mode_reg));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // Sends one command with chip select low, then deselects.
  task automatic cmd(input logic [2:0] code, input logic [1:0] bank, input logic [11:0] a);
    u_ctrl.issue(1'b0, code, bank, a);
    u_ctrl.idle();
  endtask
  // Counts burst beats over twelve cycles and keeps the last column seen.
  task automatic count_beats();
    beats = 0;
    repeat (12) begin
      if (acc_valid === 1'b1) begin
        beats++;
        last_col = acc_col;
      end
      step(1);
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    nrst_in = 1'b1;
    step(1);
    check("bank_open", 12'(bank_open), 12'h000);
    check("pwr", 12'(pwr), 12'(sdram_cmd_pkg::PWR_RUN));
    check("buf_en", 12'(buf_en), 12'h001);
    check("temp_compensated_refresh", 12'(tcr), 12'(sdram_cmd_pkg::TEMP_COMPENSATED_REFRESH_RESET));
    cmd(MRS, sdram_cmd_pkg::SEL_EXT, 12'h01D);
    step(1);
    check("partial_array_refresh", 12'(par), 12'h005);
    check("temp_compensated_refresh", 12'(tcr), 12'h003);
    u_ctrl.issue(1'b1, ACT, 2'h2, 12'h123);
    u_ctrl.idle();
    step(1);
    check("deselected", 12'(bank_open), 12'h000);
    cmd(ACT, 2'h1, 12'hABC);
    step(1);
    check("bank_open", 12'(bank_open), 12'h002);
    cmd(RD, 2'h0, 12'h005);
    count_beats();
    check("closed bank", 12'(beats), 12'h000);
    for (i = 0; i < 4; i++) begin
      cmd(MRS, sdram_cmd_pkg::SEL_MODE, 12'(i));
      check("mode", mode_reg, 12'(i));
      u_ctrl.issue(1'b0, RD, 2'h1, 12'h0FE);
      u_ctrl.idle();
      check("start col", 12'(acc_col), 12'h0FE);
      check("row", acc_row, 12'hABC);
      check("bank", 12'(acc_bank), 12'h001);
      count_beats();
      check("beats", 12'(beats), 12'(1 << i));
      check("last col", 12'(last_col), 12'((254 + (1 << i) - 1) % 256));
    end
    u_ctrl.issue(1'b0, RD, 2'h1, 12'h010);
    u_ctrl.issue(1'b0, RD, 2'h1, 12'h040);
    u_ctrl.idle();
    check("new col", 12'(acc_col), 12'h040);
    count_beats();
    check("restart beats", 12'(beats), 12'h008);
    u_ctrl.issue(1'b0, RD, 2'h1, 12'h020);
    u_ctrl.issue(1'b0, MRS, sdram_cmd_pkg::SEL_MODE, 12'h000);
    u_ctrl.issue(1'b0, BST, 2'h1, 12'h000);
    u_ctrl.idle();
    check("mode held", mode_reg, 12'h003);
    count_beats();
    check("stopped", 12'(beats), 12'h000);
    u_ctrl.issue(1'b0, WR, 2'h1, 12'h030);
    u_ctrl.set_side(1'b1, 2'b01, 1'b0);
    u_ctrl.idle();
    step(1);
    check("write", 12'(acc_write), 12'h001);
    check("wr lanes", 12'(wr_lane), 12'h002);
    u_ctrl.issue(1'b0, RD, 2'h1, 12'h050);
    u_ctrl.set_side(1'b1, 2'b10, 1'b0);
    u_ctrl.idle();
    step(3);
    check("rd lanes", 12'(rd_oe), 12'h001);
    u_ctrl.set_side(1'b1, 2'b00, 1'b0);
    count_beats();
    cmd(MRS, sdram_cmd_pkg::SEL_MODE, 12'h000);
    cmd(RD, 2'h1, 12'h407);
    step(5);
    check("auto pre", 12'(bank_open), 12'h000);
    cmd(MRS, sdram_cmd_pkg::SEL_MODE, 12'h003);
    u_ctrl.issue(1'b0, ACT, 2'h0, 12'h001);
    u_ctrl.issue(1'b0, ACT, 2'h2, 12'hFFF);
    cmd(ACT, 2'h3, 12'h800);
    step(1);
    check("open three", 12'(bank_open), 12'h00D);
    u_ctrl.issue(1'b0, RD, 2'h2, 12'h060);
    u_ctrl.issue(1'b0, PRE, 2'h3, 12'h000);
    u_ctrl.idle();
    step(1);
    check("one closed", 12'(bank_open), 12'h005);
    check("still busy", 12'(acc_valid), 12'h001);
    check("wide row", acc_row, 12'hFFF);
    count_beats();
    cmd(PRE, 2'h0, 12'h400);
    step(1);
    check("all closed", 12'(bank_open), 12'h000);
    u_ctrl.set_side(1'b0, 2'b00, 1'b0);
    step(5);
    check("pre pd", 12'(pwr), 12'(sdram_cmd_pkg::PWR_PRE_DOWN));
    check("buf off", 12'(buf_en), 12'h000);
    u_ctrl.set_side(1'b1, 2'b00, 1'b0);
    step(5);
    check("wake", 12'(pwr), 12'(sdram_cmd_pkg::PWR_RUN));
    cmd(ACT, 2'h1, 12'h00F);
    u_ctrl.set_side(1'b0, 2'b00, 1'b0);
    step(5);
    check("act pd", 12'(pwr), 12'(sdram_cmd_pkg::PWR_ACT_DOWN));
    u_ctrl.set_side(1'b1, 2'b00, 1'b0);
    step(5);
    cmd(RD, 2'h1, 12'h080);
    u_ctrl.set_side(1'b0, 2'b00, 1'b0);
    step(4);
    held_col = acc_col;
    check("suspend", 12'(pwr), 12'(sdram_cmd_pkg::PWR_SUSPEND));
    step(3);
    check("frozen col", 12'(acc_col), 12'(held_col));
    u_ctrl.set_side(1'b1, 2'b00, 1'b0);
    count_beats();
    cmd(PRE, 2'h0, 12'h400);
    u_ctrl.set_side(1'b0, 2'b00, 1'b1);
    step(5);
    check("deepest", 12'(pwr), 12'(sdram_cmd_pkg::PWR_DEEPEST));
    u_ctrl.set_side(1'b1, 2'b00, 1'b0);
    step(5);
    check("wake deepest", 12'(pwr), 12'(sdram_cmd_pkg::PWR_RUN));
    u_ctrl.set_side(1'b0, 2'b00, 1'b0);
    repeat (3) u_ctrl.issue(1'b0, REF, 2'h0, 12'h000);
    u_ctrl.idle();
    step(5);
    check("self ref", 12'(pwr), 12'(sdram_cmd_pkg::PWR_SELF_REF));
    check("buf off", 12'(buf_en), 12'h000);
    wrap_up();
  end
endmodule
